// File: rtl/sclp_link_rx.sv
// sclp_link_rx: shift-clock domain front end; assembles bytes and hands them over.
// assumes: host drives data stable around the rising shift-clock edge; reset comes
// synchronised into this domain from the system side.
`default_nettype none
module sclp_link_rx (
	input  wire logic             i_shift_clk,   // config_shift_clock from host
	input  wire logic             i_link_rst,    // synchronous reset, shift domain
	input  wire logic             i_accept,      // level: loading allowed
	input  wire logic             i_fast,        // level: fast parallel scheme
	input  wire logic             i_serial_bit,  // serial config input
	input  wire logic [7:0]       i_par_byte,    // byte-wide config input
	output logic                  o_tgl,         // toggles per captured byte
	output logic [7:0]            o_byte,        // held byte
	output logic [1:0]            o_fall_cnt     // gray count of falling edges
);
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic       byte_ready;
	logic [1:0] fall_reg;

	// sampling on the rising edge [R8]; lsb first in serial [R1]
	assign shift_next = {i_serial_bit, shift_reg[7:1]};
	assign cnt_next   = cnt_reg + 3'h1;
	assign byte_ready = i_fast | (cnt_reg == 3'h7);

	always_ff @(posedge i_shift_clk) begin
		if (i_link_rst) begin
			shift_reg <= 8'h00;
			cnt_reg   <= 3'h0;
			o_tgl     <= 1'b0;
			o_byte    <= 8'h00;
		end else if (i_accept) begin
			// toggle keeps its level while refused, so no false byte event
			shift_reg <= shift_next;
			cnt_reg   <= i_fast ? 3'h0 : cnt_next;
			if (byte_ready) begin
				o_tgl  <= ~o_tgl;
				o_byte <= i_fast ? i_par_byte : shift_next; // one byte per edge in the fast scheme, one per eight edges in serial [R7]
			end
		end
	end

	// free-running gray count of falling edges: one bit moves per edge, so the
	// system side samples it safely and measures edges from done high [R9]
	always_ff @(negedge i_shift_clk) begin
		if (i_link_rst) begin
			fall_reg <= 2'h0;
		end else begin
			fall_reg <= {fall_reg[0], ~fall_reg[1]};
		end
	end
	assign o_fall_cnt = fall_reg;
endmodule
`default_nettype wire

// File: rtl/sclp_pkg.sv
// sclp_pkg: shared constants and carrier types for the serial config load port.
// assumes: system clock i_mclk at 100 MHz; link side clocked by the host shift clock.
`default_nettype none
package sclp_pkg;
	localparam int unsigned SCLP_BYTE_W       = 8;
	localparam int unsigned SCLP_MCLK_MHZ     = 100;
	localparam int unsigned SCLP_INIT_EDGES   = 2;    // falling shift edges after load complete
	localparam int unsigned SCLP_STARTUP_CYC  = 3192; // init cycles once start-up clock runs
	localparam logic [31:0] SCLP_LEN_RST      = 32'h0000_0000;
	localparam logic [7:0]  SCLP_BYTE_RST     = 8'h00;

	typedef enum logic [1:0] {
		SCLP_PASSIVE_SERIAL_SCHEME,
		SCLP_FAST_PARALLEL_SCHEME
	} sclp_scheme_t;

	typedef enum {
		SCLP_ST_RESET,
		SCLP_ST_LOAD,
		SCLP_ST_WAIT_DONE,
		SCLP_ST_INIT,
		SCLP_ST_USER,
		SCLP_ST_ERROR
	} sclp_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} sclp_word_t;
endpackage
`default_nettype wire

// File: rtl/sclp_top.sv
// sclp_top: device side of the passive configuration load port.
// assumes: open-drain status and done lines are wired-and outside; pins are
// asynchronous to i_mclk and pass a two-stage synchroniser.
`default_nettype none
// Operation
// R1: host shifts the bitstream one bit per shift-clock edge on serial input.
// R2: host clocks until load-complete high; device accepts data while it is low.
// R3: on cable load, ignore auto-restart; only explicit reconfig request restarts.
// R4: on cable load, ignore user start-up clock option; init without it.
// R5: every device waits for shared load-complete line high before start-up.
// R6: on error, pull shared status line low, halting the chain.
// R7: fast parallel scheme takes one whole byte per shift-clock cycle.
// R8: input data sampled on the rising shift-clock edge.
// R9: host gives two more falling edges after load-complete so init begins.
// R10: reconfig request low in user mode aborts user mode and restarts load.
// R11: after finishing, drive chain-enable out low; next device accepts at once.
module sclp_top #(
	parameter int unsigned BYTES       = 16,                          // bitstream length
	parameter int unsigned STARTUP_CYC = sclp_pkg::SCLP_STARTUP_CYC    // init cycles
) (
	input  wire logic        i_mclk,                  // system clock
	input  wire logic        i_rst,                   // synchronous reset, high
	input  wire logic        i_config_shift_clock,    // host shift clock
	input  wire logic        i_serial_bit,            // serial config data
	input  wire logic [7:0]  i_par_byte,              // byte-wide config data
	input  wire logic        i_fast_parallel_scheme,  // strap: 1 = fast parallel
	input  wire logic        i_reconfig_request_n,    // active-low reconfig
	input  wire logic        i_chain_enable_in_n,     // active-low chain enable
	input  wire logic        i_config_status_n,       // status line level
	input  wire logic        i_load_complete_flag,    // shared done line level
	input  wire logic        i_cable_load,            // strap: download-cable load
	input  wire logic        i_auto_restart,          // option: restart after error
	input  wire logic        i_user_clk_opt,          // option: user start-up clock
	input  wire logic        i_user_startup_clock,    // user start-up clock pin
	input  wire logic        i_word_error,            // data checker flags bad word
	input  wire logic        i_out_ready,             // receiver ready for words
	output logic             o_config_status_n_o,     // status drive value (0)
	output logic             o_config_status_n_oe,    // status drive enable
	output logic             o_load_complete_flag_o,  // done drive value (0)
	output logic             o_load_complete_flag_oe, // done drive enable, holds low
	output logic             o_chain_enable_out_n,    // active-low chain enable out
	output logic             o_user_mode,             // device in user mode
	output logic             o_out_valid,             // config word valid
	output sclp_pkg::sclp_word_t o_out_word           // config word
);
	initial begin
		if (BYTES < 1 || STARTUP_CYC < 1) $error("sclp_top: bad parameter");
	end

	sclp_pkg::sclp_state_t state_reg, state_next;
	logic [31:0] len_reg;
	logic [31:0] init_reg;
	logic        strap_fast_reg;
	logic        accept_reg;
	logic [2:0]  tgl_s, ucl_s;
	logic [1:0]  rq_s, ce_s, st_s, dn_s;
	logic [1:0]  fall_base_reg;
	logic        done_seen_reg;
	logic        link_hold_reg;
	logic [1:0]  fall0_reg, fall1_reg;
	logic        link_rst0_reg, link_rst_reg, acc0_reg, acc_l_reg, fast0_reg, fast_l_reg;
	logic        tgl_q;
	logic [7:0]  link_byte;
	logic [1:0]  link_fall;
	logic        link_tgl;
	// two-entry buffer
	sclp_pkg::sclp_word_t buf_mem [2];
	logic        wr_ptr, rd_ptr;
	logic [1:0]  buf_cnt;

	// level crossings: first stage feeds only the second
	always_ff @(posedge i_mclk) begin
		tgl_s[0] <= link_tgl;             tgl_s[1] <= tgl_s[0];  tgl_s[2] <= tgl_s[1];
		rq_s[0]  <= i_reconfig_request_n; rq_s[1]  <= rq_s[0];
		ce_s[0]  <= i_chain_enable_in_n;  ce_s[1]  <= ce_s[0];
		st_s[0]  <= i_config_status_n;    st_s[1]  <= st_s[0];
		dn_s[0]  <= i_load_complete_flag; dn_s[1]  <= dn_s[0];
		ucl_s[0] <= i_user_startup_clock; ucl_s[1] <= ucl_s[0]; ucl_s[2] <= ucl_s[1];
		fall0_reg <= link_fall;           fall1_reg <= fall0_reg;
	end

	// system to link crossing, two flops on the shift clock
	always_ff @(posedge i_config_shift_clock) begin
		link_rst0_reg <= link_hold_reg;
		link_rst_reg  <= link_rst0_reg;
		acc0_reg      <= accept_reg;
		acc_l_reg     <= acc0_reg;
		fast0_reg     <= strap_fast_reg;
		fast_l_reg    <= fast0_reg;
	end

	sclp_link_rx u_link (
		.i_shift_clk  (i_config_shift_clock),
		.i_link_rst   (link_rst_reg),
		.i_accept     (acc_l_reg),
		.i_fast       (fast_l_reg),
		.i_serial_bit (i_serial_bit),
		.i_par_byte   (i_par_byte),
		.o_tgl        (link_tgl),
		.o_fall_cnt   (link_fall),
		.o_byte       (link_byte)
	);

	wire byte_evt   = tgl_s[2] ^ tgl_s[1];
	wire buf_full   = (buf_cnt == 2'h2);
	wire buf_empty  = (buf_cnt == 2'h0);
	// bytes that trail in after loading ends are dropped, not stored
	wire buf_push   = byte_evt & ~buf_full & (state_reg == sclp_pkg::SCLP_ST_LOAD);
	wire buf_pop    = o_out_valid & i_out_ready;
	wire last_byte  = (len_reg == BYTES - 1);
	// fast parallel flags done one byte early
	wire done_byte  = strap_fast_reg ? (len_reg == BYTES - 2) || (BYTES == 1) : last_byte;
	wire uclk_edge  = ucl_s[2] ^ ucl_s[1];
	wire use_uclk   = i_user_clk_opt & ~i_cable_load;                              // [R4]
	wire init_tick  = use_uclk ? uclk_edge : 1'b1;
	wire may_restart = i_auto_restart & ~i_cable_load;                             // [R3]
	wire load_done   = buf_push & done_byte;
	wire [1:0] fall_bin  = {fall1_reg[1], fall1_reg[1] ^ fall1_reg[0]};
	wire [1:0] fall_seen = fall_bin - fall_base_reg;
	// word path: bypass the store when it runs empty, so the register never shows stale data
	wire       rd_ptr_next   = buf_pop ? ~rd_ptr : rd_ptr;
	wire [1:0] cnt_after_pop = buf_cnt - {1'b0, buf_pop};
	wire sclp_pkg::sclp_word_t in_word = '{data: link_byte, last: done_byte};
	wire sclp_pkg::sclp_word_t next_word = (cnt_after_pop == 2'h0) ? in_word :
	                                       buf_mem[rd_ptr_next];

	// note: link byte held stable for three mclk after a toggle, since bytes
	// arrive further apart than three mclk periods; a byte arriving at a full buffer is not stored and sends loading to error
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sclp_pkg::SCLP_ST_RESET:
				if (rq_s[1] && st_s[1]) state_next = sclp_pkg::SCLP_ST_LOAD;
			sclp_pkg::SCLP_ST_LOAD: begin
				if (!rq_s[1])          state_next = sclp_pkg::SCLP_ST_RESET;
				else if (i_word_error || (byte_evt && buf_full))
					state_next = sclp_pkg::SCLP_ST_ERROR;                   // [R6]
				else if (load_done)    state_next = sclp_pkg::SCLP_ST_WAIT_DONE;
			end
			sclp_pkg::SCLP_ST_WAIT_DONE: begin
				if (!rq_s[1])          state_next = sclp_pkg::SCLP_ST_RESET;
				else if (!st_s[1])     state_next = sclp_pkg::SCLP_ST_ERROR;
				// hold start-up until shared done line and two falling edges [R5] [R9]
				else if (done_seen_reg && dn_s[1] &&
				         fall_seen >= 2'(sclp_pkg::SCLP_INIT_EDGES))
					state_next = sclp_pkg::SCLP_ST_INIT;
			end
			sclp_pkg::SCLP_ST_INIT: begin
				if (!rq_s[1])          state_next = sclp_pkg::SCLP_ST_RESET;
				else if (init_reg == STARTUP_CYC - 1 && init_tick)
					state_next = sclp_pkg::SCLP_ST_USER;
			end
			sclp_pkg::SCLP_ST_USER:
				if (!rq_s[1])          state_next = sclp_pkg::SCLP_ST_RESET;   // [R10]
			sclp_pkg::SCLP_ST_ERROR:
				// cable load waits for an explicit request [R3]
				if (!rq_s[1] || may_restart) state_next = sclp_pkg::SCLP_ST_RESET;
			default:                   state_next = sclp_pkg::SCLP_ST_RESET;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg      <= sclp_pkg::SCLP_ST_RESET;
			len_reg        <= sclp_pkg::SCLP_LEN_RST;
			init_reg       <= sclp_pkg::SCLP_LEN_RST;
			strap_fast_reg <= 1'b0;
			accept_reg     <= 1'b0;
			done_seen_reg  <= 1'b0;
			fall_base_reg  <= 2'h0;
			link_hold_reg  <= 1'b1;
		end else begin
			state_reg <= state_next;
			if (state_reg == sclp_pkg::SCLP_ST_RESET) begin
				len_reg        <= sclp_pkg::SCLP_LEN_RST;
				init_reg       <= sclp_pkg::SCLP_LEN_RST;
				strap_fast_reg <= i_fast_parallel_scheme;
			end else if (buf_push) begin
				len_reg <= len_reg + 32'h1;
			end
			if (state_reg == sclp_pkg::SCLP_ST_INIT && init_tick)
				init_reg <= init_reg + 32'h1;
			// accept while done low and chained-in enabled [R2] [R11]
			accept_reg <= (state_next == sclp_pkg::SCLP_ST_LOAD) & ~ce_s[1];
			// edge count starts once the shared done line is seen high [R9]
			if (state_reg == sclp_pkg::SCLP_ST_WAIT_DONE && dn_s[1] && !done_seen_reg) begin
				done_seen_reg <= 1'b1;
				fall_base_reg <= fall_bin;
			end else if (state_reg != sclp_pkg::SCLP_ST_WAIT_DONE) begin
				done_seen_reg <= 1'b0;
			end
			// registered so the link side never samples a decode glitch
			link_hold_reg <= (state_next == sclp_pkg::SCLP_ST_RESET);
		end
	end

	// two-entry buffer on the word path
	always_ff @(posedge i_mclk) begin
		if (i_rst || state_reg == sclp_pkg::SCLP_ST_RESET) begin
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
			buf_cnt <= 2'h0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (buf_push) begin
				buf_mem[wr_ptr] <= in_word;
				wr_ptr <= ~wr_ptr;
			end
			if (buf_pop) rd_ptr <= ~rd_ptr;
			buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_config_status_n_o     <= 1'b0;
			o_config_status_n_oe    <= 1'b1;
			o_load_complete_flag_o  <= 1'b0;
			o_load_complete_flag_oe <= 1'b1;
			o_chain_enable_out_n    <= 1'b1;
			o_user_mode             <= 1'b0;
			o_out_valid             <= 1'b0;
			o_out_word              <= '0;
		end else begin
			o_config_status_n_o     <= 1'b0;
			// released in reset once the request is gone, else the shared line
			// could never rise and loading would never start
			o_config_status_n_oe    <= (state_next == sclp_pkg::SCLP_ST_ERROR) ||
			                           (state_next == sclp_pkg::SCLP_ST_RESET && !rq_s[1]); // [R6]
			o_load_complete_flag_o  <= 1'b0;
			o_load_complete_flag_oe <= (state_next == sclp_pkg::SCLP_ST_LOAD) ||
			                           (state_next == sclp_pkg::SCLP_ST_RESET) ||
			                           (state_next == sclp_pkg::SCLP_ST_ERROR);
			o_chain_enable_out_n    <= ~((state_next == sclp_pkg::SCLP_ST_WAIT_DONE) ||
			                             (state_next == sclp_pkg::SCLP_ST_INIT) ||
			                             (state_next == sclp_pkg::SCLP_ST_USER));  // [R11]
			o_user_mode             <= (state_next == sclp_pkg::SCLP_ST_USER);
			o_out_valid             <= (buf_cnt - {1'b0, buf_pop} + {1'b0, buf_push}) != 2'h0;
			o_out_word              <= next_word;
		end
	end

	chk_error_pulls_status: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
		state_reg == sclp_pkg::SCLP_ST_ERROR |-> o_config_status_n_oe)
		else $error("status not pulled low in error");
	chk_cable_no_restart: assert property (@(posedge i_mclk) disable iff (i_rst) // [R3]
		state_reg == sclp_pkg::SCLP_ST_ERROR && i_cable_load && rq_s[1]
		|=> state_reg == sclp_pkg::SCLP_ST_ERROR)
		else $error("cable load restarted without request");
	chk_startup_waits_done: assert property (@(posedge i_mclk) disable iff (i_rst) // [R5]
		state_reg == sclp_pkg::SCLP_ST_WAIT_DONE && !dn_s[1]
		|=> state_reg != sclp_pkg::SCLP_ST_INIT)
		else $error("start-up before shared done");
	chk_reconfig_aborts: assert property (@(posedge i_mclk) disable iff (i_rst) // [R10]
		state_reg == sclp_pkg::SCLP_ST_USER && !rq_s[1] |=> ##1 !o_user_mode)
		else $error("user mode not aborted");
	chk_chain_out_low: assert property (@(posedge i_mclk) disable iff (i_rst) // [R11]
		state_reg == sclp_pkg::SCLP_ST_WAIT_DONE |-> !o_chain_enable_out_n)
		else $error("chain enable out not low after load");
	chk_done_held_low: assert property (@(posedge i_mclk) disable iff (i_rst) // [R2]
		accept_reg |-> o_load_complete_flag_oe)
		else $error("done released while accepting");
	chk_cable_no_uclk: assert property (@(posedge i_mclk) disable iff (i_rst) // [R4]
		state_reg == sclp_pkg::SCLP_ST_INIT && i_cable_load |-> init_tick)
		else $error("cable init waits on user clock");
	chk_fast_byte_count: assert property (@(posedge i_mclk) disable iff (i_rst) // [R7]
		buf_push && state_reg == sclp_pkg::SCLP_ST_LOAD |=> len_reg == $past(len_reg) + 32'h1)
		else $error("byte not counted");
endmodule
`default_nettype wire

// File: verification/sclp_host_model.sv
// sclp_host_model: behavioural configuration host that makes the shift clock and data.
// assumes: driven by task calls from the bench; shift clock rests low between frames.
`default_nettype none
module sclp_host_model (
	output logic       o_shift_clk,  // shift clock, 12 ns period inside frames
	output logic       o_serial_bit, // serial config data
	output logic [7:0] o_par_byte    // byte-wide config data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_shift_clk = 1'b0;
		o_serial_bit = 1'b0;
		o_par_byte = 8'h00;
	end

	// data only moves while the clock is low, so it is settled at the rising edge
	task automatic pulse();
		#6 o_shift_clk = 1'b1;
		#6 o_shift_clk = 1'b0;
	endtask

	// also gives the falling edges that start initialisation
	task automatic pulses(input int n);
		repeat (n) pulse();
	endtask

	task automatic send_byte(input logic [7:0] b, input logic fast);
		if (fast) begin
			o_par_byte = b;
			pulse();
			#40; // device needs four system cycles per byte
		end else begin
			for (int i = 0; i < 8; i++) begin
				o_serial_bit = b[i];
				pulse();
			end
		end
		// released lines must not keep showing the last value
		o_serial_bit = ~o_serial_bit;
		o_par_byte = ~o_par_byte;
	endtask
endmodule
`default_nettype wire

// File: verification/sclp_top_tb_top.sv
// sclp_top_tb_top: self-checking bench for the serial config load port.
// assumes: sclp_host_model plays the host; shared open-drain lines have pull-ups here.
`default_nettype none
module sclp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned NB = 4;
	logic                 mclk, rst, shift_clk, ser_bit, fast, cfg_n, cable, auto_rst;
	logic                 uopt, werr, rdy, other_low, st_o, st_oe, dn_o, dn_oe;
	logic                 chain_out_n, user_mode, out_valid, ce_n, uclk;
	logic [7:0]           par;
	sclp_pkg::sclp_word_t out_word;
	sclp_pkg::sclp_word_t got_q[$];
	int                   miscompares = 0;
	int                   total_checks = 0;
	wire logic            status_line = ~(st_oe & ~st_o);
	wire logic            done_line = ~(dn_oe & ~dn_o) & ~other_low;

	sclp_host_model i_sclp_host_model (.o_shift_clk(shift_clk), .o_serial_bit(ser_bit),
		.o_par_byte(par));
	sclp_top #(.BYTES(NB), .STARTUP_CYC(8)) i_sclp_top (.i_mclk(mclk), .i_rst(rst),
		.i_config_shift_clock(shift_clk), .i_serial_bit(ser_bit), .i_par_byte(par),
		.i_fast_parallel_scheme(fast), .i_reconfig_request_n(cfg_n),
		.i_chain_enable_in_n(ce_n), .i_config_status_n(status_line),
		.i_load_complete_flag(done_line), .i_cable_load(cable), .i_auto_restart(auto_rst),
		.i_user_clk_opt(uopt), .i_user_startup_clock(uclk), .i_word_error(werr),
		.i_out_ready(rdy), .o_config_status_n_o(st_o), .o_config_status_n_oe(st_oe),
		.o_load_complete_flag_o(dn_o), .o_load_complete_flag_oe(dn_oe),
		.o_chain_enable_out_n(chain_out_n), .o_user_mode(user_mode),
		.o_out_valid(out_valid), .o_out_word(out_word));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (out_valid === 1'b1 && rdy === 1'b1) got_q.push_back(out_word);
	end

	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	task automatic chk_word(input sclp_pkg::sclp_word_t got, input sclp_pkg::sclp_word_t exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
	endtask

	function automatic logic [7:0] pat(input logic [7:0] k);
		return 8'h5a ^ (k * 8'h13);
	endfunction

	// shift clock must also run during reset to clear the link side
	task automatic do_reset(input logic f, input logic c, input logic a, input logic o);
		@(posedge mclk);
		rst <= 1'b1; fast <= f; cable <= c; auto_rst <= a; uopt <= o;
		cfg_n <= 1'b1; werr <= 1'b0; other_low <= 1'b0; rdy <= 1'b1;
		fork
			wait_clk(8);
			i_sclp_host_model.pulses(6);
		join
		@(posedge mclk);
		rst <= 1'b0;
		wait_clk(20);
		// two idle edges carry reset and accept levels into the link before data
		i_sclp_host_model.pulses(2);
		got_q.delete();
	endtask

	task automatic sc_serial_load();
		do_reset(1'b0, 1'b1, 1'b0, 1'b1);
		fork
			for (int k = 0; k < NB - 1; k++) i_sclp_host_model.send_byte(pat(8'(k)), 1'b0);
			begin
				wait_clk(12); rdy <= 1'b0; wait_clk(10); rdy <= 1'b1;
			end
		join
		wait_clk(20);
		chk1(dn_oe, 1'b1, "done released early");
		chk1(chain_out_n, 1'b1, "chain out low early");
		i_sclp_host_model.send_byte(pat(8'(NB - 1)), 1'b0);
		wait_clk(20);
		chk1(dn_oe, 1'b0, "done still held");
		chk1(chain_out_n, 1'b0, "chain out not low");
		chk1(got_q.size() == NB, 1'b1, "word count");
		for (int k = 0; k < NB && k < got_q.size(); k++)
			chk_word(got_q[k], '{data: pat(8'(k)), last: (k == NB - 1)});
		other_low <= 1'b1;
		i_sclp_host_model.pulses(2);
		wait_clk(40);
		chk1(user_mode, 1'b0, "started while shared done low");
		other_low <= 1'b0;
		i_sclp_host_model.pulses(2);
		wait_clk(40);
		chk1(user_mode, 1'b1, "no user mode without user clock");
	endtask

	task automatic sc_reconfig();
		cfg_n <= 1'b0;
		wait_clk(5);
		chk1(user_mode, 1'b0, "user mode kept");
		chk1(dn_oe, 1'b1, "done not pulled low");
		cfg_n <= 1'b1;
		wait_clk(20);
		chk1(st_oe, 1'b0, "no new load started");
	endtask

	task automatic sc_fast_load();
		ce_n <= 1'b1;
		do_reset(1'b1, 1'b0, 1'b0, 1'b1);
		i_sclp_host_model.send_byte(pat(8'h00), 1'b1);
		wait_clk(20);
		chk1(got_q.size() == 0, 1'b1, "loaded while chain in high");
		ce_n <= 1'b0;
		wait_clk(5);
		i_sclp_host_model.pulses(2);
		for (int k = 0; k < NB - 2; k++) i_sclp_host_model.send_byte(pat(8'(k)), 1'b1);
		wait_clk(20);
		chk1(dn_oe, 1'b1, "fast done early");
		i_sclp_host_model.send_byte(pat(8'(NB - 2)), 1'b1);
		wait_clk(20);
		chk1(dn_oe, 1'b0, "fast done missing");
		chk1(got_q.size() > 0 && got_q[0].data === pat(8'h00), 1'b1, "fast byte");
		i_sclp_host_model.pulses(2);
		wait_clk(40);
		chk1(user_mode, 1'b0, "init ran without user clock");
		repeat (10) begin
			wait_clk(3);
			uclk <= ~uclk;
		end
		wait_clk(10);
		chk1(user_mode, 1'b1, "fast no user mode");
	endtask

	task automatic sc_error();
		do_reset(1'b0, 1'b1, 1'b1, 1'b0);
		i_sclp_host_model.send_byte(pat(8'h00), 1'b0);
		werr <= 1'b1;
		wait_clk(3);
		werr <= 1'b0;
		wait_clk(5);
		chk1(status_line, 1'b0, "status not pulled low");
		wait_clk(60);
		chk1(st_oe, 1'b1, "auto restart on cable load");
		cfg_n <= 1'b0;
		wait_clk(5);
		cfg_n <= 1'b1;
		wait_clk(20);
		chk1(st_oe, 1'b0, "no restart on request");
	endtask

	initial begin
		rst = 1'b1; fast = 1'b0; cfg_n = 1'b1; cable = 1'b0; auto_rst = 1'b0;
		uopt = 1'b0; werr = 1'b0; rdy = 1'b1; other_low = 1'b0;
		ce_n = 1'b0; uclk = 1'b0;
		sc_serial_load();
		sc_reconfig();
		sc_fast_load();
		sc_error();
		report_and_stop();
	end

	initial begin
		#100us;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
